// >>> pkg/fsq_pkg.sv
// Purpose: Constants and types for the host-side flash command controller.
// Assumes: 10 MHz controller clock, 16-bit flash data bus, 22-bit word address.
// Notes:   Unlock addresses and command codes are plain defaults, adjust per part.
package fsq_pkg;

    localparam int          CLK_MHZ     = 10;
    localparam int          AW          = 22;
    localparam int          DW          = 16;

    // Pin timing, least values, rounded up to whole clock cycles
    localparam int          T_SETUP_NS  = 100;
    localparam int          T_WP_NS     = 100;
    localparam int          T_ACCESS_NS = 200;
    localparam int          T_GAP_NS    = 100;
    localparam logic [3:0]  SETUP_CYC   = 4'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  WP_CYC      = 4'((T_WP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  ACCESS_CYC  = 4'((T_ACCESS_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  GAP_CYC     = 4'((T_GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [3:0]  SYNC_CYC    = 4'h2;

    // Software register offsets
    localparam logic [7:0]  REG_CTRL    = 8'h00;
    localparam logic [7:0]  REG_ADDR    = 8'h04;
    localparam logic [7:0]  REG_WDATA   = 8'h08;
    localparam logic [7:0]  REG_STATUS  = 8'h0c;
    localparam logic [7:0]  REG_RDATA   = 8'h10;

    // Status field positions
    localparam int          ST_BUSY     = 0;
    localparam int          ST_QUERY    = 1;
    localparam int          ST_SECURED  = 2;
    localparam int          ST_REFUSED  = 3;
    localparam int          ST_LOCKOUT  = 4;
    localparam int          ST_LOCKED   = 5;

    // Flash command words
    localparam logic [AW-1:0] UNLOCK1_ADDR = 22'h000555;
    localparam logic [AW-1:0] UNLOCK2_ADDR = 22'h0002aa;
    localparam logic [AW-1:0] QUERY_ADDR   = 22'h000055;
    localparam logic [DW-1:0] UNLOCK1_DATA = 16'h00aa;
    localparam logic [DW-1:0] UNLOCK2_DATA = 16'h0055;
    localparam logic [DW-1:0] CMD_QUERY    = 16'h0098;
    localparam logic [DW-1:0] CMD_RESET    = 16'h00f0;
    localparam logic [DW-1:0] CMD_SEC_IN   = 16'h0088;
    localparam logic [DW-1:0] CMD_SEC_OUT  = 16'h0090;
    localparam logic [DW-1:0] CMD_SEC_END  = 16'h0000;
    localparam logic [DW-1:0] CMD_PROTECT  = 16'h0060;

    typedef enum logic [2:0] {
        FSQ_OP_READ, FSQ_OP_WRITE, FSQ_OP_QUERY, FSQ_OP_RESET,
        FSQ_OP_SEC_ENTER, FSQ_OP_SEC_EXIT, FSQ_OP_LOCK
    } fsq_op_t;

    typedef enum logic [2:0] {
        FSQ_IDLE, FSQ_SETUP, FSQ_STROBE, FSQ_HOLD, FSQ_READ, FSQ_GAP
    } fsq_st_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } fsq_word_t;

    typedef struct packed {
        fsq_st_t       st;
        fsq_op_t       op;
        logic [2:0]    step;
        logic [3:0]    cnt;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [DW-1:0] rdata;
        logic          query;
        logic          secured;
        logic          locked;
        logic          refused;
        logic          ce_n;
        logic          we_n;
        logic          oe_n;
        logic [AW-1:0] pin_a;
        logic [DW-1:0] pin_dq;
        logic          dq_oe;
        logic [31:0]   rd_data;
        logic [DW-1:0] dq_s1;
        logic [DW-1:0] dq_s2;
        logic          lk_s1;
        logic          lk_s2;
    } fsq_state_t;

    // Strobes idle high from reset so nothing looks like a write cycle
    localparam fsq_state_t RESET_STATE = '{
        st: FSQ_IDLE, op: FSQ_OP_READ, step: 3'h0, cnt: 4'h0,
        addr: '0, wdata: '0, rdata: '0, query: 1'b0, secured: 1'b0,
        locked: 1'b0, refused: 1'b0, ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
        pin_a: '0, pin_dq: '0, dq_oe: 1'b0, rd_data: '0,
        dq_s1: '0, dq_s2: '0, lk_s1: 1'b0, lk_s2: 1'b0
    };

endpackage

// >>> src/fsq_host_ctrl.sv
// Purpose: Host controller that drives an asynchronous NOR flash through its
//          chip select, write strobe, output enable, address and data pins.
// Assumes: 10 MHz clock; flash pins are asynchronous to it; software port
//          with one-cycle strobes and read data one cycle later.
// Notes:   Lock issues the protect write and the whole exit sequence as one
//          operation; mode flags shadow the mode the flash should sit in.
// Operation
// - Lock: enter secured region, then protect.
// - Host exits secured region after locking.
// - Write only when select, strobe low, enable high.
// - Query entry: data 98h at word 55h.
// - Host writes reset to leave query.
// - Secured access: three writes in, four out.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module fsq_host_ctrl (
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_rstn,
    input  wire logic [7:0]               i_addr,
    input  wire logic [31:0]              i_wr_data,
    input  wire logic                     i_wr,
    input  wire logic                     i_rd,
    output logic      [31:0]              o_rd_data,
    input  wire logic                     i_lockout,
    output logic                          o_ce_n,
    output logic                          o_we_n,
    output logic                          o_oe_n,
    output logic      [fsq_pkg::AW-1:0]   o_a,
    output logic      [fsq_pkg::DW-1:0]   o_dq,
    output logic                          o_dq_oe,
    input  wire logic [fsq_pkg::DW-1:0]   i_dq
);

    // All state in one packed struct, registered in one place
    fsq_pkg::fsq_state_t s_q;
    fsq_pkg::fsq_state_t s_d;

    // Number of bus cycles making up each operation
    function automatic logic [2:0] op_len(input fsq_pkg::fsq_op_t op);
        case (op)
            fsq_pkg::FSQ_OP_SEC_ENTER: op_len = 3'h3;
            fsq_pkg::FSQ_OP_SEC_EXIT:  op_len = 3'h4;
            fsq_pkg::FSQ_OP_LOCK:      op_len = 3'h5;
            default:                   op_len = 3'h1;
        endcase
    endfunction

    // Four-write exit sequence, shared by the exit and lock operations
    function automatic fsq_pkg::fsq_word_t exit_word(input logic [2:0] step,
                                                      input logic [fsq_pkg::AW-1:0] a);
        case (step)
            3'h0:    exit_word = '{fsq_pkg::UNLOCK1_ADDR, fsq_pkg::UNLOCK1_DATA};
            3'h1:    exit_word = '{fsq_pkg::UNLOCK2_ADDR, fsq_pkg::UNLOCK2_DATA};
            3'h2:    exit_word = '{fsq_pkg::UNLOCK1_ADDR, fsq_pkg::CMD_SEC_OUT};
            default: exit_word = '{a, fsq_pkg::CMD_SEC_END};
        endcase
    endfunction

    // Address and data of one bus cycle of an operation
    function automatic fsq_pkg::fsq_word_t seq_word(input fsq_pkg::fsq_op_t op,
                                                     input logic [2:0] step,
                                                     input logic [fsq_pkg::AW-1:0] a,
                                                     input logic [fsq_pkg::DW-1:0] d);
        case (op)
            fsq_pkg::FSQ_OP_QUERY:
                seq_word = '{fsq_pkg::QUERY_ADDR, fsq_pkg::CMD_QUERY};
            fsq_pkg::FSQ_OP_RESET:
                seq_word = '{a, fsq_pkg::CMD_RESET};    // Any address is fine
            fsq_pkg::FSQ_OP_SEC_ENTER: begin
                if (step == 3'h0) begin
                    seq_word = '{fsq_pkg::UNLOCK1_ADDR, fsq_pkg::UNLOCK1_DATA};
                end else if (step == 3'h1) begin
                    seq_word = '{fsq_pkg::UNLOCK2_ADDR, fsq_pkg::UNLOCK2_DATA};
                end else begin
                    seq_word = '{fsq_pkg::UNLOCK1_ADDR, fsq_pkg::CMD_SEC_IN};
                end
            end
            fsq_pkg::FSQ_OP_SEC_EXIT:
                seq_word = exit_word(step, a);
            fsq_pkg::FSQ_OP_LOCK: begin
                // Protect write first, then the exit sequence follows unasked
                if (step == 3'h0) begin
                    seq_word = '{a, fsq_pkg::CMD_PROTECT};
                end else begin
                    seq_word = exit_word(step - 3'h1, a);
                end
            end
            default:
                seq_word = '{a, d};
        endcase
    endfunction

    // All next-state logic in one place
    always_comb begin
        fsq_pkg::fsq_word_t w;
        fsq_pkg::fsq_op_t   new_op;
        logic               bad;
        s_d    = s_q;
        w      = seq_word(s_q.op, s_q.step, s_q.addr, s_q.wdata);
        new_op = fsq_pkg::fsq_op_t'(i_wr_data[2:0]);
        bad    = 1'b0;

        // Pins are asynchronous: two flops before anything reads them
        s_d.dq_s1 = i_dq;
        s_d.dq_s2 = s_q.dq_s1;
        s_d.lk_s1 = i_lockout;
        s_d.lk_s2 = s_q.lk_s1;

        // Register reads, answer in the next cycle
        if (i_rd) begin
            if (i_addr == fsq_pkg::REG_CTRL) begin
                s_d.rd_data = {29'h0, s_q.op};
            end else if (i_addr == fsq_pkg::REG_ADDR) begin
                s_d.rd_data = {10'h0, s_q.addr};
            end else if (i_addr == fsq_pkg::REG_WDATA) begin
                s_d.rd_data = {16'h0, s_q.wdata};
            end else if (i_addr == fsq_pkg::REG_STATUS) begin
                s_d.rd_data = {26'h0, s_q.locked, s_q.lk_s2, s_q.refused,
                               s_q.secured, s_q.query, (s_q.st != fsq_pkg::FSQ_IDLE)};
            end else if (i_addr == fsq_pkg::REG_RDATA) begin
                s_d.rd_data = {16'h0, s_q.rdata};
            end else begin
                s_d.rd_data = 32'h0;
            end
        end

        // Register writes; clear of the refused flag comes before any new set
        if (i_wr) begin
            if (i_addr == fsq_pkg::REG_ADDR) begin
                if (s_q.st == fsq_pkg::FSQ_IDLE) begin
                    s_d.addr = i_wr_data[fsq_pkg::AW-1:0];
                end else begin
                    bad = 1'b1;
                end
            end else if (i_addr == fsq_pkg::REG_WDATA) begin
                if (s_q.st == fsq_pkg::FSQ_IDLE) begin
                    s_d.wdata = i_wr_data[fsq_pkg::DW-1:0];
                end else begin
                    bad = 1'b1;
                end
            end else if (i_addr == fsq_pkg::REG_STATUS) begin
                if (i_wr_data[fsq_pkg::ST_REFUSED]) begin
                    s_d.refused = 1'b0;
                end
            end else if (i_addr == fsq_pkg::REG_CTRL) begin
                // Refuse while busy, during supply lockout, for a lock outside
                // secured mode, for a second lock, and for array writes while
                // query mode still owns the bus
                if (s_q.st != fsq_pkg::FSQ_IDLE || s_q.lk_s2 ||
                    new_op > fsq_pkg::FSQ_OP_LOCK ||
                    (new_op == fsq_pkg::FSQ_OP_LOCK &&
                     (!s_q.secured || s_q.locked)) ||
                    (new_op == fsq_pkg::FSQ_OP_WRITE && s_q.query)) begin
                    bad = 1'b1;
                end else begin
                    s_d.op   = new_op;
                    s_d.step = 3'h0;
                    s_d.cnt  = fsq_pkg::SETUP_CYC;
                    s_d.st   = fsq_pkg::FSQ_SETUP;
                end
            end
        end
        // A refusal raised in this cycle outranks any clear of the flag
        if (bad) begin
            s_d.refused = 1'b1;
        end

        // Flash bus cycle sequencer
        case (s_q.st)
            fsq_pkg::FSQ_IDLE: begin
                // Strobes stay high so no write is seen at power-up
                s_d.ce_n  = 1'b1;
                s_d.we_n  = 1'b1;
                s_d.oe_n  = 1'b1;
                s_d.dq_oe = 1'b0;
            end
            fsq_pkg::FSQ_SETUP: begin
                // Address and data settle with select low, both strobes high
                s_d.ce_n   = 1'b0;
                s_d.oe_n   = 1'b1;
                s_d.we_n   = 1'b1;
                s_d.pin_a  = w.addr;
                s_d.pin_dq = w.data;
                s_d.dq_oe  = (s_q.op != fsq_pkg::FSQ_OP_READ);
                // The first cycle drives select, address and any write data only; a strobe in the same
                // cycle would meet an address that is still moving
                if (s_q.cnt > 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else if (s_q.op == fsq_pkg::FSQ_OP_READ) begin
                    s_d.oe_n = 1'b0;                 // Same handshake for table words
                    s_d.cnt  = 4'(fsq_pkg::ACCESS_CYC + fsq_pkg::SYNC_CYC);
                    s_d.st   = fsq_pkg::FSQ_READ;
                end else begin
                    s_d.we_n = 1'b0;                 // Write: select, strobe low, enable high
                    s_d.cnt  = fsq_pkg::WP_CYC;
                    s_d.st   = fsq_pkg::FSQ_STROBE;
                end
            end
            fsq_pkg::FSQ_STROBE: begin
                // Width counted in whole clocks, so a slower clock only lengthens it
                if (s_q.cnt > 4'h1) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.we_n = 1'b1;                 // Rising strobe latches the data
                    s_d.st   = fsq_pkg::FSQ_HOLD;
                end
            end
            fsq_pkg::FSQ_HOLD: begin
                // Select rises one cycle after the strobe; data held through it
                s_d.ce_n = 1'b1;
                s_d.cnt  = fsq_pkg::GAP_CYC;
                s_d.st   = fsq_pkg::FSQ_GAP;
            end
            fsq_pkg::FSQ_READ: begin
                // Wait access time plus the synchroniser depth, then sample
                if (s_q.cnt > 4'h1) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    // Synced word is taken before the enable rises, never after
                    s_d.rdata = s_q.dq_s2;
                    s_d.oe_n  = 1'b1;
                    s_d.ce_n  = 1'b1;
                    s_d.cnt   = fsq_pkg::GAP_CYC;
                    s_d.st    = fsq_pkg::FSQ_GAP;
                end
            end
            fsq_pkg::FSQ_GAP: begin
                // Data released only after select rose, never under a live select
                s_d.dq_oe = 1'b0;
                if (s_q.cnt > 4'h1) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else if (s_q.step + 3'h1 < op_len(s_q.op)) begin
                    s_d.step = s_q.step + 3'h1;
                    s_d.cnt  = fsq_pkg::SETUP_CYC;
                    s_d.st   = fsq_pkg::FSQ_SETUP;
                end else begin
                    s_d.st = fsq_pkg::FSQ_IDLE;
                    // Track the mode the flash now sits in
                    case (s_q.op)
                        fsq_pkg::FSQ_OP_QUERY:     s_d.query   = 1'b1;
                        fsq_pkg::FSQ_OP_RESET:     s_d.query   = 1'b0;
                        fsq_pkg::FSQ_OP_SEC_ENTER: s_d.secured = 1'b1;
                        fsq_pkg::FSQ_OP_SEC_EXIT:  s_d.secured = 1'b0;
                        fsq_pkg::FSQ_OP_LOCK: begin
                            s_d.secured = 1'b0;
                            s_d.locked  = 1'b1;
                        end
                        default: s_d.secured = s_q.secured;
                    endcase
                end
            end
            default: begin
                s_d.st = fsq_pkg::FSQ_IDLE;
            end
        endcase

        // Low supply throws the flash back to array read, so the shadow modes
        // follow; a mode the flash has left must not steer later refusals
        if (s_q.lk_s2) begin
            s_d.query   = 1'b0;
            s_d.secured = 1'b0;
        end
    end

    // State register; reset forces idle pins with strobes high
    // The reset branch loads a constant only, so nothing races the reset
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s_q <= fsq_pkg::RESET_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign o_rd_data = s_q.rd_data;
    assign o_ce_n    = s_q.ce_n;
    assign o_we_n    = s_q.we_n;
    assign o_oe_n    = s_q.oe_n;
    assign o_a       = s_q.pin_a;
    assign o_dq      = s_q.pin_dq;
    assign o_dq_oe   = s_q.dq_oe;

endmodule // fsq_host_ctrl

// >>> verification/fsq_flash_model.sv
// Purpose: Behavioural flash device on the far side of the host controller.
// Assumes: No clock; writes latch on the write strobe rising edge.
// Notes:   Never busy, so no embedded algorithm ever blocks a command.
`timescale 1ns/1ps
module fsq_flash_model (
    input  wire logic        i_ce_n,
    input  wire logic        i_we_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_lockout,
    input  wire logic [21:0] i_a,
    input  wire logic [15:0] i_dq,
    output logic      [15:0] o_dq
);
    // Query table, word 10h first
    localparam logic [0:75][7:0] QTBL = {88'h51_52_59_02_00_40_00_00_00_00_00,
        96'h27_36_00_00_04_00_0a_00_05_00_04_00,
        200'h17_02_00_00_00_03_07_00_20_00_7d_00_00_00_07_00_20_00_00_00_00_00_00_00_00,
        136'h50_52_49_31_33_04_02_01_01_04_77_00_00_85_95_01_01,
        88'h00_00_00_00_00_00_04_17_30_30_17};
    logic [1:0]  seq = 2'h0;
    logic        query = 1'b0;
    logic        sec = 1'b0;
    logic        locked = 1'b0;
    logic [15:0] word;
    logic [15:0] last = 16'h0000;
    // Word selected by the current mode
    always_comb begin
        if (query) word = (i_a >= 22'h10 && i_a <= 22'h5b) ? {8'h00, QTBL[i_a[6:0] - 7'h10]} : 16'h0;
        else if (sec && i_a[21:12] == 10'h0) word = 16'hc000 ^ i_a[15:0];
        else word = ~i_a[15:0];
    end
    // Released bus shows the inverse of the last word so stale data never passes
    always @(posedge i_oe_n) last <= word;
    assign o_dq = (!i_ce_n && !i_oe_n) ? word : ~last;
    // Command decode; low supply drops every mode and ignores writes
    // No bypass or accelerated programming mode exists here
    always @(posedge i_we_n or posedge i_lockout) begin
        if (i_lockout) begin
            seq <= 2'h0;
            query <= 1'b0;
            sec <= 1'b0;
        end else if (!i_ce_n && i_oe_n) begin
            if (i_dq == 16'h00f0) begin
                query <= 1'b0;
                seq <= 2'h0;
            end else if (i_dq == 16'h0098 && i_a == 22'h55) query <= 1'b1;
            else if (seq == 2'h0 && i_a == 22'h555 && i_dq == 16'h00aa) seq <= 2'h1;
            else if (seq == 2'h1 && i_a == 22'h2aa && i_dq == 16'h0055) seq <= 2'h2;
            else if (seq == 2'h2 && i_dq == 16'h0088) begin
                sec <= 1'b1;
                seq <= 2'h0;
            end else if (seq == 2'h2 && i_dq == 16'h0090) seq <= 2'h3;
            else if (seq == 2'h3 && i_dq == 16'h0000) begin
                sec <= 1'b0;
                seq <= 2'h0;
            end else if (sec && i_dq == 16'h0060) locked <= 1'b1; // no unlock path
            else seq <= 2'h0;
        end
    end
endmodule // fsq_flash_model

// >>> verification/fsq_host_ctrl_assertions.sv
// Purpose: Pin and port timing checks for the host flash controller.
// Assumes: One clock domain, bound to every fsq_host_ctrl.
// Notes:   Watches what the controller drives, plus the read strobe i_rd.
`timescale 1ns/1ps
module fsq_host_ctrl_assertions (
    input wire logic                   i_ref_clk,
    input wire logic                   i_rstn,
    input wire logic                   i_rd,
    input wire logic [31:0]            o_rd_data,
    input wire logic                   o_ce_n,
    input wire logic                   o_we_n,
    input wire logic                   o_oe_n,
    input wire logic [fsq_pkg::AW-1:0] o_a,
    input wire logic [fsq_pkg::DW-1:0] o_dq,
    input wire logic                   o_dq_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);
    // A strobe outside a qualified cycle could start a stray write
    write_gate_a: assert property (!o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe)
        else $error("write strobe outside a qualified cycle");
    strobe_width_a: assert property ($fell(o_we_n) |=> o_we_n && !o_ce_n ##1 o_ce_n && o_dq_oe ##1 !o_dq_oe)
        else $error("write cycle shape wrong");
    write_setup_a: assert property ($fell(o_we_n) |-> $past(o_ce_n, 2) && !$past(o_ce_n))
        else $error("select not set up one cycle before strobe");
    pins_stand_a: assert property (!o_ce_n && !$past(o_ce_n) |-> $stable(o_a) && (!o_dq_oe || $stable(o_dq)))
        else $error("address or data moved in a cycle");
    read_gate_a: assert property ($fell(o_oe_n) |-> !o_ce_n && !o_dq_oe && !$past(o_ce_n))
        else $error("read enable outside a selected cycle");
    read_width_a: assert property ($fell(o_oe_n) |=> !o_oe_n [*3] ##1 o_oe_n && o_ce_n)
        else $error("read enable width wrong");
    rdata_hold_a: assert property (!$past(i_rd) |-> $stable(o_rd_data))
        else $error("read data moved without a read");
    query_addr_a: assert property ($fell(o_we_n) && o_dq == fsq_pkg::CMD_QUERY |-> o_a == fsq_pkg::QUERY_ADDR)
        else $error("query command at wrong address");
    cycle_gap_a: assert property ($rose(o_ce_n) |=> o_ce_n)
        else $error("no deselect gap between cycles");
endmodule // fsq_host_ctrl_assertions
bind fsq_host_ctrl fsq_host_ctrl_assertions u_chk (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_rd(i_rd), .o_rd_data(o_rd_data), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_a(o_a), .o_dq(o_dq), .o_dq_oe(o_dq_oe));

// >>> verification/fsq_host_ctrl_bench.sv
// Purpose: Self-checking bench driving the controller through its register port.
// Assumes: Flash model on the pins; 10 MHz clock.
// Notes:   Status is checked as the six low bits after every operation except reads and the second secured entry.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin failures++; \
    $display("[ERR] %s expected %h seen %h", what, exp, got); end end
module fsq_host_ctrl_bench;
    logic                   i_ref_clk = 1'b0;
    logic                   i_rstn    = 1'b0;
    logic                   i_wr      = 1'b0;
    logic                   i_rd      = 1'b0;
    logic                   i_lockout = 1'b0;
    logic [7:0]             i_addr    = 8'h00;
    logic [31:0]            i_wr_data = 32'h0;
    logic [31:0]            o_rd_data;
    logic                   o_ce_n, o_we_n, o_oe_n, o_dq_oe;
    logic [fsq_pkg::AW-1:0] o_a;
    logic [fsq_pkg::DW-1:0] o_dq, flash_dq, i_dq;
    logic [31:0]            rd;
    int                     failures = 0;
    int                     n_compared = 0;
    int                     cycles = 0;
    // Query words to read back: address in 23:16, word below
    localparam logic [23:0] QW [28] = '{24'h100051, 24'h110052, 24'h120059, 24'h130002,
        24'h150040, 24'h190000, 24'h1f0004, 24'h21000a, 24'h230005, 24'h250004, 24'h270017,
        24'h280002, 24'h2c0003, 24'h2f0020, 24'h31007d, 24'h390000, 24'h400050, 24'h420049,
        24'h450004, 24'h460002, 24'h490004, 24'h4a0077, 24'h4f0001, 24'h500001, 24'h570004,
        24'h580017, 24'h590030, 24'h5b0017};
    always #50 i_ref_clk = ~i_ref_clk;
    assign i_dq = o_dq_oe ? o_dq : flash_dq;
    fsq_host_ctrl uut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
        .i_lockout(i_lockout), .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
        .o_a(o_a), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .i_dq(i_dq));
    fsq_flash_model flash (.i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
        .i_lockout(i_lockout), .i_a(o_a), .i_dq(i_dq), .o_dq(flash_dq));
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One-cycle strobes, with an idle edge between calls
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wr_data <= d;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1 d = o_rd_data;
    endtask
    // Start an operation and poll busy under a bound
    task automatic run_op(input fsq_pkg::fsq_op_t op, input logic [21:0] a, input logic [15:0] d);
        int n;
        reg_wr(fsq_pkg::REG_ADDR, {10'h0, a});
        reg_wr(fsq_pkg::REG_WDATA, {16'h0, d});
        reg_wr(fsq_pkg::REG_CTRL, {29'h0, op});
        n = 0;
        do begin
            reg_rd(fsq_pkg::REG_STATUS, rd);
            n++;
        end while (rd[fsq_pkg::ST_BUSY] !== 1'b0 && n < 100);
        `CHK("busy", 1'b0, rd[fsq_pkg::ST_BUSY]);
    endtask
    task automatic st_is(input logic [5:0] e);
        reg_rd(fsq_pkg::REG_STATUS, rd);
        `CHK("status", e, rd[5:0]);
    endtask
    task automatic word_is(input logic [21:0] a, input logic [15:0] e);
        run_op(fsq_pkg::FSQ_OP_READ, a, 16'h0000);
        reg_rd(fsq_pkg::REG_RDATA, rd);
        `CHK("read word", e, rd[15:0]);
    endtask
    // Hang guard, far above the fewer than a thousand cycles the tests need
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 8000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        #1 `CHK("idle pins", 4'b1110, {o_ce_n, o_we_n, o_oe_n, o_dq_oe});
        st_is(6'h00);
        run_op(fsq_pkg::FSQ_OP_QUERY, 22'h0, 16'h0);
        st_is(6'h02);
        `CHK("device query", 1'b1, flash.query);
        foreach (QW[i]) word_is({14'h0, QW[i][23:16]}, QW[i][15:0]);
        run_op(fsq_pkg::FSQ_OP_WRITE, 22'h100, 16'h1234);
        st_is(6'h0a);
        reg_wr(fsq_pkg::REG_STATUS, 32'h8);
        run_op(fsq_pkg::FSQ_OP_RESET, 22'h3ff, 16'h0);
        st_is(6'h00);
        word_is(22'h10, 16'hffef);
        $display("query test done");
        run_op(fsq_pkg::FSQ_OP_LOCK, 22'h0, 16'h0);
        st_is(6'h08);
        reg_wr(fsq_pkg::REG_STATUS, 32'h8);
        run_op(fsq_pkg::FSQ_OP_SEC_ENTER, 22'h0, 16'h0);
        st_is(6'h04);
        word_is(22'h5, 16'hc005);
        run_op(fsq_pkg::FSQ_OP_LOCK, 22'h0, 16'h0);
        st_is(6'h20);
        `CHK("device lock", 1'b1, flash.locked);
        word_is(22'h5, 16'hfffa);
        run_op(fsq_pkg::FSQ_OP_SEC_ENTER, 22'h0, 16'h0);
        run_op(fsq_pkg::FSQ_OP_LOCK, 22'h0, 16'h0);
        st_is(6'h2c);
        reg_wr(fsq_pkg::REG_STATUS, 32'h8);
        run_op(fsq_pkg::FSQ_OP_SEC_EXIT, 22'h0, 16'h0);
        st_is(6'h20);
        $display("secured sector test done");
        run_op(fsq_pkg::FSQ_OP_QUERY, 22'h0, 16'h0);
        st_is(6'h22);
        @(posedge i_ref_clk) i_lockout <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        run_op(fsq_pkg::FSQ_OP_QUERY, 22'h0, 16'h0);
        st_is(6'h38);
        `CHK("device query", 1'b0, flash.query);
        @(posedge i_ref_clk) i_lockout <= 1'b0;
        repeat (4) @(posedge i_ref_clk);
        reg_wr(fsq_pkg::REG_STATUS, 32'h8);
        st_is(6'h20);
        $display("lockout test done");
        complete_run();
    end
endmodule // fsq_host_ctrl_bench
